/* File: design/power_button_pwm_adc_ctrl.sv */
// power sequencing, switched usb ports, adc references and pwm control
`timescale 1ns/1ps
`default_nettype none
`include "power_ctrl_params.svh"
module power_button_pwm_adc_ctrl #(
    parameter int unsigned HOLD_ON_CYC      = `HOLD_ON_CYC,
    parameter int unsigned HOLD_OFF_CYC     = `HOLD_OFF_CYC,
    parameter int unsigned DEBOUNCE_CYC     = `DEBOUNCE_CYC,
    parameter int unsigned SERVO_PERIOD_CYC = `SERVO_PERIOD_CYC,
    parameter int unsigned SERVO_MIN_CYC    = `SERVO_MIN_CYC,
    parameter int unsigned SERVO_MAX_CYC    = `SERVO_MAX_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // register port
    input  wire logic [7:0]             addr,
    input  wire logic [15:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [15:0]                 rdata,
    // power request pin and wake/sleep conditions
    input  wire logic                   manual_power_request_n,
    input  wire logic                   start_ok,
    input  wire logic                   rtc_alarm,
    input  wire logic                   batt_charged,
    input  wire logic                   low_batt,
    // usb power switches
    input  wire logic [1:0]             usb_oc,
    output logic                        sys_power_en,
    output logic                        usb_always_en,
    output logic [1:0]                  usb_sw_en,
    // analog inputs
    input  wire logic [9:0]             adc0_result,
    input  wire logic [9:0]             adc1_result,
    output power_ctrl_pkg::adc_ref_e    adc0_ref,
    output power_ctrl_pkg::adc_ref_e    adc1_ref,
    // pwm and interrupt
    output logic [1:0]                  pwm_out,
    output logic                        irq
);
    import power_ctrl_pkg::*;

    // pin synchronisers: button and overcurrent flags
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_s3_reg;
    logic [2:0] pin_clean_reg;

    // button debounce and hold timing
    logic        btn_deb_reg;
    logic [31:0] deb_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic        consumed_reg;

    // power state and usb switches
    pwr_state_e  state_reg;
    pwr_state_e  state_next;
    logic [1:0]  usb_en_reg;
    logic [1:0]  usb_en_next;

    // software registers
    logic [1:0]  usb_def_reg;
    logic [3:0]  status_reg;
    logic [3:0]  status_next;
    logic [3:0]  mask_reg;
    logic [3:0]  adc_ref_reg;
    logic [3:0]  pwm_mode_reg;
    logic [7:0]  pwm0_reg;
    logic [7:0]  pwm1_reg;
    logic [15:0] rdata_reg;

    // register decode
    wire wr_ctrl   = wr && (addr == `REG_CTRL);
    wire wr_cfg    = wr && (addr == `REG_CFG);
    wire wr_status = wr && (addr == `REG_STATUS);
    wire wr_mask   = wr && (addr == `REG_MASK);
    wire wr_ref    = wr && (addr == `REG_ADC_REF);
    wire wr_mode   = wr && (addr == `REG_PWM_MODE);
    wire wr_pwm0   = wr && (addr == `REG_PWM0);
    wire wr_pwm1   = wr && (addr == `REG_PWM1);

    // button is asserted when the pin is low
    wire        btn_raw   = !pin_clean_reg[0];
    wire [1:0]  oc_clean  = pin_clean_reg[2:1];
    wire [2:0]  pin_agree = ~(pin_s2_reg ^ pin_s3_reg);

    wire deb_done    = (deb_cnt_reg >= DEBOUNCE_CYC - 1);
    wire hold_on_hit  = btn_deb_reg && !consumed_reg && (hold_cnt_reg >= HOLD_ON_CYC);
    wire hold_off_hit = btn_deb_reg && !consumed_reg && (hold_cnt_reg >= HOLD_OFF_CYC);
    wire sw_off       = wr_ctrl && wdata[`CTRL_SW_OFF_BIT];

    wire is_up   = (state_reg == PWR_UP);
    wire go_up   = !is_up && ((hold_on_hit && start_ok) || rtc_alarm || batt_charged);
    wire go_down = is_up && (hold_off_hit || low_batt || sw_off);
    wire acted   = (hold_on_hit && go_up) || (hold_off_hit && go_down);

    wire [1:0] oc_event = oc_clean & usb_en_reg & {2{is_up}};
    wire [3:0] events   = {oc_event, go_down, go_up};

    // power state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PWR_DOWN: if (go_up) state_next = PWR_UP;
            PWR_UP:   if (go_down) state_next = PWR_DOWN;
            default:  state_next = PWR_DOWN;
        endcase
    end

    // switchable usb ports: defaults at power-up, off on overcurrent or sleep
    always_comb begin
        usb_en_next = usb_en_reg;
        if (go_up)
            usb_en_next = usb_def_reg;
        else if (!is_up || go_down)
            usb_en_next = 2'h0;
        else begin
            if (wr_ctrl)
                usb_en_next = wdata[`CTRL_USB_LSB +: 2];
            usb_en_next = usb_en_next & ~oc_clean;
        end
    end

    // sticky events, set wins over a write-one clear
    assign status_next = (status_reg & ~(wr_status ? wdata[3:0] : 4'h0)) | events;

    // read selection
    wire [15:0] rd_mux =
        (addr == `REG_CTRL)     ? {13'h0, usb_en_reg, 1'b0} :
        (addr == `REG_CFG)      ? {14'h0, usb_def_reg} :
        (addr == `REG_STATUS)   ? {12'h0, status_reg} :
        (addr == `REG_MASK)     ? {12'h0, mask_reg} :
        (addr == `REG_STATE)    ? {12'h0, oc_clean, btn_deb_reg, is_up} :
        (addr == `REG_ADC_REF)  ? {12'h0, adc_ref_reg} :
        (addr == `REG_ADC0)     ? {6'h0, adc0_result} :
        (addr == `REG_ADC1)     ? {6'h0, adc1_result} :
        (addr == `REG_PWM_MODE) ? {12'h0, pwm_mode_reg} :
        (addr == `REG_PWM0)     ? {8'h0, pwm0_reg} :
        (addr == `REG_PWM1)     ? {8'h0, pwm1_reg} :
        16'h0000;

    // three-stage pin sampling; a change is taken when stages two and three agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1_reg    <= 3'h1;
            pin_s2_reg    <= 3'h1;
            pin_s3_reg    <= 3'h1;
            pin_clean_reg <= 3'h1;
        end else begin
            pin_s1_reg    <= {usb_oc, manual_power_request_n};
            pin_s2_reg    <= pin_s1_reg;
            pin_s3_reg    <= pin_s2_reg;
            pin_clean_reg <= (pin_s3_reg & pin_agree) | (pin_clean_reg & ~pin_agree);
        end
    end

    // debounce: level must hold for the debounce time before it is taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            btn_deb_reg <= 1'b0;
            deb_cnt_reg <= 32'h0;
        end else begin
            deb_cnt_reg <= (btn_raw == btn_deb_reg || deb_done) ? 32'h0 : deb_cnt_reg + 32'h1;
            if (btn_raw != btn_deb_reg && deb_done)
                btn_deb_reg <= btn_raw;
        end
    end

    // hold timer; one action per hold, rearmed on release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_reg <= 32'h0;
            consumed_reg <= 1'b0;
        end else begin
            if (!btn_deb_reg)
                hold_cnt_reg <= 32'h0;
            else if (hold_cnt_reg != 32'hFFFFFFFF)
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
            consumed_reg <= btn_deb_reg && (consumed_reg || acted);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg  <= PWR_DOWN;
            usb_en_reg <= 2'h0;
            status_reg <= 4'h0;
            rdata_reg  <= 16'h0000;
        end else begin
            state_reg  <= state_next;
            usb_en_reg <= usb_en_next;
            status_reg <= status_next;
            rdata_reg  <= rd ? rd_mux : 16'h0000;
        end
    end

    // software configuration
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            usb_def_reg  <= `USB_DEF_RST;
            mask_reg     <= `MASK_RST;
            adc_ref_reg  <= `ADC_REF_RST;
            pwm_mode_reg <= `PWM_MODE_RST;
            pwm0_reg     <= `PWM_SET_RST;
            pwm1_reg     <= `PWM_SET_RST;
        end else begin
            if (wr_cfg)  usb_def_reg  <= wdata[1:0];
            if (wr_mask) mask_reg     <= wdata[3:0];
            if (wr_ref)  adc_ref_reg  <= wdata[3:0];
            if (wr_mode) pwm_mode_reg <= wdata[3:0];
            if (wr_pwm0) pwm0_reg     <= wdata[7:0];
            if (wr_pwm1) pwm1_reg     <= wdata[7:0];
        end
    end

    // pwm channels
    pwm_if pif[2] ();
    for (genvar i = 0; i < 2; i++) begin : g_pwm
        assign pif[i].setting = (i == 0) ? pwm0_reg : pwm1_reg;
        assign pif[i].mode    = pwm_mode_e'(pwm_mode_reg[2*i +: 2]);
        pwm_channel #(
            .SERVO_PERIOD_CYC (SERVO_PERIOD_CYC),
            .SERVO_MIN_CYC    (SERVO_MIN_CYC),
            .SERVO_MAX_CYC    (SERVO_MAX_CYC)
        ) u_chan (
            .sys_clk (sys_clk),
            .rst     (rst),
            .bus     (pif[i])
        );
        assign pwm_out[i] = pif[i].out;
    end

    assign rdata         = rdata_reg;
    assign sys_power_en  = is_up;
    assign usb_always_en = is_up;
    assign usb_sw_en     = usb_en_reg;
    assign adc0_ref      = adc_ref_e'(adc_ref_reg[1:0]);
    assign adc1_ref      = adc_ref_e'(adc_ref_reg[3:2]);
    assign irq           = |(status_reg & mask_reg);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sw_off_write;
        wr && addr == `REG_CTRL && wdata[`CTRL_SW_OFF_BIT];
    endsequence
    sequence status_read;
        rd && addr == `REG_STATUS;
    endsequence
    sequence up_edge;
        !is_up ##1 is_up;
    endsequence

    wake_cause_a: assert property (up_edge |-> $past(go_up) && ($past(rtc_alarm) ||
            $past(batt_charged) || ($past(start_ok) && $past(hold_cnt_reg) >= HOLD_ON_CYC)))
        else $error("power-up without a wake cause");
    hold_down_a: assert property (is_up && hold_off_hit |=> !is_up && status_reg[`ST_DOWN_BIT])
        else $error("long hold did not power down");
    low_batt_a: assert property (is_up && low_batt |=> !is_up)
        else $error("low battery did not power down");
    sw_off_a: assert property (is_up ##0 sw_off_write |=> !is_up ##1 !usb_always_en)
        else $error("software power-down ignored");
    usb_sleep_a: assert property (!is_up |-> usb_sw_en == 2'h0 && !usb_always_en)
        else $error("usb power on while system is down");
    usb_default_a: assert property (up_edge |-> usb_en_reg == $past(usb_def_reg))
        else $error("usb ports missed their power-up default");
    oc_cut_a: assert property (is_up && usb_en_reg[0] && oc_clean[0] |=> !usb_en_reg[0])
        else $error("overcurrent did not remove port power");
    oc_flag_a: assert property (is_up && usb_en_reg[1] && oc_clean[1] |=> status_reg[3] [*2])
        else $error("overcurrent fault flag not held");
    once_press_a: assert property (consumed_reg |-> !acted ##1 (consumed_reg || !btn_deb_reg))
        else $error("second action within one hold");
    status_read_a: assert property (status_read ##1 !wr_status |-> rdata[3:0] == $past(status_reg))
        else $error("status read returned wrong data");
    irq_mask_a: assert property ($rose(status_reg[0]) && mask_reg[0] |-> irq)
        else $error("unmasked event did not raise interrupt");
endmodule : power_button_pwm_adc_ctrl
`default_nettype wire

/* File: design/power_ctrl_params.svh */
// offsets, reset values and timing counts for the power/pwm/adc controller
`ifndef POWER_CTRL_PARAMS_SVH
`define POWER_CTRL_PARAMS_SVH

// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_CFG         8'h04
`define REG_STATUS      8'h08
`define REG_MASK        8'h0C
`define REG_STATE       8'h10
`define REG_ADC_REF     8'h14
`define REG_ADC0        8'h18
`define REG_ADC1        8'h1C
`define REG_PWM_MODE    8'h20
`define REG_PWM0        8'h24
`define REG_PWM1        8'h28

// field positions
`define CTRL_SW_OFF_BIT 0
`define CTRL_USB_LSB    1
`define ST_UP_BIT       0
`define ST_DOWN_BIT     1
`define ST_OC_LSB       2

// reset values
`define USB_DEF_RST     2'h0
`define ADC_REF_RST     4'hF
`define PWM_MODE_RST    4'h0
`define PWM_SET_RST     8'h00
`define MASK_RST        4'h0

// timing
`define CLK_HZ          10000000
`define CLK_PERIOD_NS   100
`define CLK_PER_MS      (`CLK_HZ / 1000)
`define PWR_ON_HOLD_MS  2000
`define PWR_OFF_HOLD_MS 6000
`define DEBOUNCE_MS     20
`define HOLD_ON_CYC     (`PWR_ON_HOLD_MS * `CLK_PER_MS)
`define HOLD_OFF_CYC    (`PWR_OFF_HOLD_MS * `CLK_PER_MS)
`define DEBOUNCE_CYC    (`DEBOUNCE_MS * `CLK_PER_MS)
`define PWM_STEPS       255
`define PWM_SLOW_HZ     732
`define PWM_MEDIUM_HZ   2930
`define PWM_FAST_HZ     46875
`define PWM_SLOW_DIV    (`CLK_HZ / (`PWM_SLOW_HZ * `PWM_STEPS))
`define PWM_MEDIUM_DIV  (`CLK_HZ / (`PWM_MEDIUM_HZ * `PWM_STEPS))
`define PWM_FAST_DIV    (`CLK_HZ / (`PWM_FAST_HZ * `PWM_STEPS))
`define SERVO_PERIOD_NS 20000000
`define SERVO_MIN_NS    817300
`define SERVO_MAX_NS    2182700
`define SERVO_PERIOD_CYC (`SERVO_PERIOD_NS / `CLK_PERIOD_NS)
`define SERVO_MIN_CYC   ((`SERVO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SERVO_MAX_CYC   (`SERVO_MAX_NS / `CLK_PERIOD_NS)

`endif

/* File: design/power_ctrl_pkg.sv */
// types shared by the power/pwm/adc controller
package power_ctrl_pkg;
    typedef enum logic [1:0] {PWM_SLOW, PWM_MEDIUM, PWM_FAST, PWM_SERVO} pwm_mode_e;
    typedef enum logic {PWR_DOWN, PWR_UP} pwr_state_e;
    typedef enum logic [1:0] {REF_1V024, REF_2V048, REF_4V096, REF_SUPPLY} adc_ref_e;
endpackage : power_ctrl_pkg

/* File: design/pwm_if.sv */
// setting, mode and output of one pwm channel
`timescale 1ns/1ps
`default_nettype none
interface pwm_if;
    import power_ctrl_pkg::*;
    logic [7:0] setting;
    pwm_mode_e  mode;
    logic       out;
    modport ctrl (output setting, output mode, input out);
    modport chan (input setting, input mode, output out);
endinterface : pwm_if
`default_nettype wire

/* File: design/pwm_channel.sv */
// one pwm channel: three fixed-rate duty modes and a servo mode
`timescale 1ns/1ps
`default_nettype none
`include "power_ctrl_params.svh"
module pwm_channel #(
    parameter int unsigned SERVO_PERIOD_CYC = `SERVO_PERIOD_CYC,
    parameter int unsigned SERVO_MIN_CYC    = `SERVO_MIN_CYC,
    parameter int unsigned SERVO_MAX_CYC    = `SERVO_MAX_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // channel
    pwm_if.chan      bus
);
    import power_ctrl_pkg::*;

    // prescale per step; never below one cycle
    function automatic logic [7:0] step_div(input pwm_mode_e m);
        int unsigned d;
        d = (m == PWM_SLOW) ? `PWM_SLOW_DIV : (m == PWM_MEDIUM) ? `PWM_MEDIUM_DIV : `PWM_FAST_DIV;
        if (d < 1) d = 1;
        return 8'(d);
    endfunction : step_div

    // linear map of setting onto the servo pulse range
    function automatic logic [31:0] servo_width(input logic [7:0] s);
        return 32'(SERVO_MIN_CYC + (32'(s) * (SERVO_MAX_CYC - SERVO_MIN_CYC)) / `PWM_STEPS);
    endfunction : servo_width

    logic [7:0]  presc_reg;
    logic [7:0]  step_reg;
    logic [31:0] servo_cnt_reg;
    logic        out_reg;

    wire        servo    = (bus.mode == PWM_SERVO);
    wire [7:0]  div      = step_div(bus.mode);
    wire        tick     = (presc_reg >= div - 8'h01);
    wire        step_end = (step_reg >= 8'(`PWM_STEPS - 1));
    wire        srv_end  = (servo_cnt_reg >= SERVO_PERIOD_CYC - 1);
    wire [31:0] width    = servo_width(bus.setting);
    wire        out_next = servo ? (servo_cnt_reg < width) : (step_reg < bus.setting);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presc_reg     <= 8'h00;
            step_reg      <= 8'h00;
            servo_cnt_reg <= 32'h0;
            out_reg       <= 1'b0;
        end else begin
            presc_reg     <= (servo || tick) ? 8'h00 : presc_reg + 8'h01;
            if (!servo && tick)
                step_reg  <= step_end ? 8'h00 : step_reg + 8'h01;
            servo_cnt_reg <= (!servo || srv_end) ? 32'h0 : servo_cnt_reg + 32'h1;
            out_reg       <= out_next;
        end
    end

    assign bus.out = out_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    duty_zero_a: assert property (!servo && bus.setting == 8'h00 && $stable(bus.mode) |=> !out_reg)
        else $error("zero duty produced a high output");
    duty_full_a: assert property (!servo && bus.setting == 8'hFF && $stable(bus.mode) |=> out_reg)
        else $error("full duty produced a low output");
    servo_bound_a: assert property (servo && $past(servo) && out_reg |-> $past(servo_cnt_reg) < SERVO_MAX_CYC)
        else $error("servo pulse exceeded its longest width");
    servo_min_a: assert property (servo && servo_cnt_reg < SERVO_MIN_CYC && $stable(bus.mode) |=> out_reg)
        else $error("servo pulse shorter than its least width");
    servo_wrap_a: assert property (servo && srv_end |=> servo_cnt_reg == 32'h0)
        else $error("servo period did not wrap");
endmodule : pwm_channel
`default_nettype wire

/* File: test/button_model.sv */
// push-button model on the active-low power request line
`timescale 1ns/1ps
`default_nettype none
module button_model (
    // power request pin
    output wire logic manual_power_request_n
);
    logic pressed = 1'b0;
    // released line is driven high by the model
    assign manual_power_request_n = pressed ? 1'b0 : 1'b1;
    // caller keeps the line low for the whole hold time
    task automatic press(input logic down);
        pressed <= down;
    endtask : press
endmodule : button_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the power/pwm/adc controller
`timescale 1ns/1ps
`default_nettype none
`include "power_ctrl_params.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    import power_ctrl_pkg::*;
    typedef struct packed {logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e; logic [3:0] r;} row_s;
    typedef struct packed {logic [1:0] m; logic [7:0] s; int per; int e;} pwm_row_s;
    logic sys_clk, rst, wr, rd, start_ok, rtc_alarm, batt_charged, low_batt;
    logic sys_power_en, usb_always_en, irq;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, c0, c1;
    logic [1:0]  usb_oc, usb_sw_en, pwm_out;
    logic [9:0]  adc0_result, adc1_result;
    wire         btn_n;
    adc_ref_e    adc0_ref, adc1_ref;
    int          num_errors = 0, n_tests = 0, cyc = 0, n;
    row_s rows [11] = '{
        '{`REG_CFG, 0, 0, 16'h0000, 4'hF}, '{`REG_MASK, 0, 0, 16'h0000, 4'hF},
        '{`REG_PWM_MODE, 0, 0, 16'h0000, 4'hF}, '{`REG_ADC_REF, 0, 0, 16'h000F, 4'hF},
        '{`REG_ADC_REF, 1, 16'h0004, 16'h0004, 4'h4}, '{`REG_ADC_REF, 1, 16'h000B, 16'h000B, 4'hB},
        '{`REG_ADC_REF, 1, 16'h0006, 16'h0006, 4'h6}, '{`REG_ADC_REF, 1, 16'h0009, 16'h0009, 4'h9},
        '{`REG_ADC0, 0, 0, 16'h02A5, 4'h9}, '{`REG_ADC1, 0, 0, 16'h015A, 4'h9},
        '{8'h30, 1, 16'hFFFF, 16'h0000, 4'h9}};
    pwm_row_s prow [8] = '{'{2'h2, 8'd100, 255, 100}, '{2'h1, 8'd51, 3315, 663},
        '{2'h0, 8'd10, 13515, 530}, '{2'h2, 8'd255, 255, 255}, '{2'h2, 8'd0, 255, 0},
        '{2'h3, 8'd0, 2000, 80}, '{2'h3, 8'd255, 2000, 220}, '{2'h3, 8'd128, 2000, 150}};

    button_model BTN (.manual_power_request_n(btn_n));
    power_button_pwm_adc_ctrl #(.HOLD_ON_CYC(200), .HOLD_OFF_CYC(600), .DEBOUNCE_CYC(10),
        .SERVO_PERIOD_CYC(2000), .SERVO_MIN_CYC(80), .SERVO_MAX_CYC(220)) DUT (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .manual_power_request_n(btn_n), .start_ok(start_ok),
        .rtc_alarm(rtc_alarm), .batt_charged(batt_charged), .low_batt(low_batt),
        .usb_oc(usb_oc), .sys_power_en(sys_power_en), .usb_always_en(usb_always_en),
        .usb_sw_en(usb_sw_en), .adc0_result(adc0_result), .adc1_result(adc1_result),
        .adc0_ref(adc0_ref), .adc1_ref(adc1_ref), .pwm_out(pwm_out), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : chk_reg

    // bounded wait on the power state, returns cycles spent
    task automatic wait_pwr(input logic v, input int lim, output int k);
        k = 0;
        #1;
        while (sys_power_en !== v && k < lim) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
    endtask : wait_pwr

    task automatic btn(input logic down, input int hold);
        @(posedge sys_clk);
        BTN.press(down);
        repeat (hold) @(posedge sys_clk);
    endtask : btn

    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
        start_ok = 1'b0; rtc_alarm = 1'b0; batt_charged = 1'b0; low_batt = 1'b0;
        usb_oc = 2'h0; adc0_result = 10'h2A5; adc1_result = 10'h15A;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK({sys_power_en, usb_always_en, usb_sw_en, irq}, 5'h00)
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            chk_reg(rows[i].a, rows[i].e);
            `CHK({adc1_ref, adc0_ref}, rows[i].r)
        end
        btn(1'b1, 260);
        `CHK(sys_power_en, 1'b0)
        btn(1'b0, 30);
        wr_reg(`REG_CFG, 16'h0001);
        wr_reg(`REG_MASK, 16'h000F);
        start_ok <= 1'b1;
        btn(1'b1, 0);
        wait_pwr(1'b1, 400, n);
        `CHK(n >= 200, 1'b1)
        `CHK({sys_power_en, usb_always_en, usb_sw_en, irq}, 5'h1B)
        chk_reg(`REG_STATUS, 16'h0001);
        chk_reg(`REG_STATE, 16'h0003);
        repeat (700) @(posedge sys_clk);
        `CHK(sys_power_en, 1'b1)
        btn(1'b0, 30);
        wr_reg(`REG_STATUS, 16'h0001);
        chk_reg(`REG_STATUS, 16'h0000);
        `CHK(irq, 1'b0)
        usb_oc <= 2'h1;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(usb_sw_en, 2'h0)
        chk_reg(`REG_STATUS, 16'h0004);
        `CHK({irq, usb_always_en}, 2'h3)
        usb_oc <= 2'h0;
        repeat (8) @(posedge sys_clk);
        wr_reg(`REG_STATUS, 16'h0004);
        wr_reg(`REG_CTRL, 16'h0006);
        chk_reg(`REG_CTRL, 16'h0006);
        `CHK(usb_sw_en, 2'h3)
        // second port faults with its status bit masked off
        wr_reg(`REG_MASK, 16'h0007);
        usb_oc <= 2'h2;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(usb_sw_en, 2'h1)
        chk_reg(`REG_STATUS, 16'h0008);
        `CHK(irq, 1'b0)
        usb_oc <= 2'h0;
        adc0_result <= 10'h3FF;
        adc1_result <= 10'h001;
        repeat (8) @(posedge sys_clk);
        chk_reg(`REG_ADC0, 16'h03FF);
        chk_reg(`REG_ADC1, 16'h0001);
        wr_reg(`REG_STATUS, 16'h0008);
        foreach (prow[i]) begin
            wr_reg(`REG_PWM_MODE, {12'h000, prow[i].m, prow[i].m});
            wr_reg(`REG_PWM0, {8'h00, prow[i].s});
            wr_reg(`REG_PWM1, {8'h00, prow[i].s});
            repeat (prow[i].per) @(posedge sys_clk);
            c0 = 16'h0000;
            c1 = 16'h0000;
            repeat (prow[i].per) begin
                @(posedge sys_clk);
                #1;
                c0 = c0 + {15'h0000, pwm_out[0]};
                c1 = c1 + {15'h0000, pwm_out[1]};
            end
            `CHK(c0, 16'(prow[i].e))
            `CHK(c1, 16'(prow[i].e))
        end
        @(posedge sys_clk);
        low_batt <= 1'b1;
        wait_pwr(1'b0, 4, n);
        `CHK({sys_power_en, usb_always_en, usb_sw_en}, 4'h0)
        low_batt <= 1'b0;
        rtc_alarm <= 1'b1;
        wait_pwr(1'b1, 4, n);
        `CHK(sys_power_en, 1'b1)
        rtc_alarm <= 1'b0;
        wr_reg(`REG_CTRL, 16'h0001);
        wait_pwr(1'b0, 4, n);
        `CHK(sys_power_en, 1'b0)
        @(posedge sys_clk);
        batt_charged <= 1'b1;
        wait_pwr(1'b1, 4, n);
        `CHK(sys_power_en, 1'b1)
        batt_charged <= 1'b0;
        btn(1'b1, 0);
        wait_pwr(1'b0, 800, n);
        `CHK(n >= 600, 1'b1)
        `CHK(sys_power_en, 1'b0)
        btn(1'b0, 30);
        @(posedge sys_clk);
        rtc_alarm <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b1;
        rtc_alarm <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK({sys_power_en, usb_sw_en, adc0_ref, adc1_ref}, 7'h0F)
        chk_reg(`REG_ADC_REF, 16'h000F);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
